/* src/isf_consts.vh */
`ifndef ISF_CONSTS_VH
`define ISF_CONSTS_VH
// ==========================================================
// register offsets (byte addresses)
`define ISF_OFF_STATUS 4'h0
`define ISF_OFF_TXHOLD 4'h4
`define ISF_OFF_RXHOLD 4'h8
`define ISF_OFF_CTRL 4'hc
// ==========================================================
// status field positions
`define ISF_B_ACK 15
`define ISF_B_TX 14
`define ISF_B_COLL 10
`define ISF_B_GCALL 9
`define ISF_B_TEN 8
`define ISF_B_WCOL 7
`define ISF_B_OVF 6
`define ISF_B_DA 5
`define ISF_B_RBF 1
`define ISF_B_TBF 0
// ==========================================================
// reset values
`define ISF_STAT_RST 16'h0000
`define ISF_BYTE_RST 8'h00
`define ISF_CTRL_RST 8'h00
// ==========================================================
// timing: one byte slot = 8 data bits plus ack
`define ISF_SLOT_BITS 4'h9
`endif

/* src/isf_status.v */
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "isf_consts.vh"
// Behaviour
// - tx flag high through 8 bits plus ack, unless lost arbitration drops it first
// - collision flag set on lost arbitration
// - general call flag set, cleared at stop
// - ten-bit match flag set, cleared at stop
// - busy tx write rejected, sets sticky flag
module isf_status (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // bus sequencer events (asynchronous, synchronised here)
    input wire ack_slot_end_i,
    input wire ack_sampled_n_i,
    input wire tx_start_i,
    input wire coll_det_i,
    input wire stop_det_i,
    input wire gcall_match_i,
    input wire ten_match_i,
    input wire rx_byte_i,
    input wire [7:0] rx_data_i,
    input wire busy_i,
    input wire data_byte_i,
    // outputs to the sequencer
    output reg tx_load_o,
    output reg [7:0] tx_byte_o,
    output reg master_tx_active_o,
    output reg [7:0] ctrl_o
);
    // ==========================================================
    // synchronisers
    // event slots in the synchronised vector
    localparam EV_ACK = 9;
    localparam EV_NACK = 8;
    localparam EV_TX = 7;
    localparam EV_COLL = 6;
    localparam EV_STOP = 5;
    localparam EV_GC = 4;
    localparam EV_TEN = 3;
    localparam EV_RX = 2;
    localparam EV_BUSY = 1;
    localparam EV_DATA = 0;
    wire [9:0] raw;
    wire [9:0] syn;
    wire [7:0] rx_syn;
    assign raw = {ack_slot_end_i, ack_sampled_n_i, tx_start_i, coll_det_i, stop_det_i,
                  gcall_match_i, ten_match_i, rx_byte_i, busy_i, data_byte_i};
    isf_sync #(.WIDTH(10)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(raw),
        .q_o(syn)
    );
    // rx data takes the same two flops, so it lines up with its strobe's edge
    isf_sync #(.WIDTH(8)) u_sync_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(rx_data_i),
        .q_o(rx_syn)
    );
    // edge detect after sync; pulses are one cycle
    // history resets low, the idle level of every strobe, so no false edge
    reg [9:0] prev_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 10'h000;
        end else begin
            prev_q <= syn;
        end
    end
    wire [9:0] rise = syn & ~prev_q;
    wire ev_ack = rise[EV_ACK];
    wire nack_lvl = syn[EV_NACK];
    wire ev_tx = rise[EV_TX];
    wire ev_coll = rise[EV_COLL];
    wire ev_stop = rise[EV_STOP];
    wire ev_gc = rise[EV_GC];
    wire ev_ten = rise[EV_TEN];
    wire ev_rx = rise[EV_RX];
    wire busy = syn[EV_BUSY] | master_tx_active_o;
    wire data_lvl = syn[EV_DATA];
    // ==========================================================
    // bus decode
    function sel_hit;
        input [3:0] adr;
        input [3:0] off;
        begin
            sel_hit = (adr == off);
        end
    endfunction
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i;
    wire rd = req & ~wb_we_i;
    wire wr_stat = wr & sel_hit(wb_adr_i, `ISF_OFF_STATUS) & wb_sel_i[0];
    wire wr_tx = wr & sel_hit(wb_adr_i, `ISF_OFF_TXHOLD) & wb_sel_i[0];
    wire wr_ctl = wr & sel_hit(wb_adr_i, `ISF_OFF_CTRL) & wb_sel_i[0];
    wire rd_rx = rd & sel_hit(wb_adr_i, `ISF_OFF_RXHOLD);
    // ==========================================================
    // flags
    reg ack_q, coll_q, gc_q, ten_q, wcol_q, ovf_q, full_q, da_q;
    reg [7:0] rx_q;
    reg [3:0] bitcnt_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            coll_q <= 1'b0;
            gc_q <= 1'b0;
            ten_q <= 1'b0;
            wcol_q <= 1'b0;
            ovf_q <= 1'b0;
            full_q <= 1'b0;
            da_q <= 1'b0;
            rx_q <= `ISF_BYTE_RST;
            bitcnt_q <= 4'h0;
            master_tx_active_o <= 1'b0;
            tx_load_o <= 1'b0;
            tx_byte_o <= `ISF_BYTE_RST;
            ctrl_o <= `ISF_CTRL_RST;
        end else begin
            tx_load_o <= 1'b0;
            if (ev_ack) begin
                ack_q <= nack_lvl;
            end
            // tx flag covers eight bits and the ack slot; a slot end seen
            // before the eighth bit is not ours and leaves the flag up
            if (wr_tx && !busy) begin
                tx_byte_o <= wb_dat_i[7:0];
                tx_load_o <= 1'b1;
                master_tx_active_o <= 1'b1;
                bitcnt_q <= `ISF_SLOT_BITS;
            end else if (ev_coll && master_tx_active_o) begin
                // lost arbitration ends the transfer, else busy would stick
                master_tx_active_o <= 1'b0;
                bitcnt_q <= 4'h0;
            end else if (ev_ack && master_tx_active_o && bitcnt_q == 4'h1) begin
                master_tx_active_o <= 1'b0;
                bitcnt_q <= 4'h0;
            end else if (ev_tx && master_tx_active_o && bitcnt_q > 4'h1) begin
                bitcnt_q <= bitcnt_q - 4'h1;
            end
            // software writes one to clear; a same-cycle event wins
            if (ev_coll) begin
                coll_q <= 1'b1;
            end else if (wr_stat && wb_dat_i[`ISF_B_COLL]) begin
                coll_q <= 1'b0;
            end
            if (ev_gc) begin
                gc_q <= 1'b1;
            end else if (ev_stop) begin
                gc_q <= 1'b0;
            end
            if (ev_ten) begin
                ten_q <= 1'b1;
            end else if (ev_stop) begin
                ten_q <= 1'b0;
            end
            if (wr_tx && busy) begin
                wcol_q <= 1'b1;
            end else if (wr_stat && wb_dat_i[`ISF_B_WCOL]) begin
                wcol_q <= 1'b0;
            end
            if (ev_rx && full_q) begin
                ovf_q <= 1'b1;
            end else if (wr_stat && wb_dat_i[`ISF_B_OVF]) begin
                ovf_q <= 1'b0;
            end
            // overflowed byte is dropped, earlier byte kept
            if (ev_rx && !full_q) begin
                rx_q <= rx_syn;
                full_q <= 1'b1;
                da_q <= data_lvl;
            end else if (rd_rx) begin
                full_q <= 1'b0;
            end
            if (wr_ctl) begin
                ctrl_o <= wb_dat_i[7:0];
            end
        end
    end
    // ==========================================================
    // read mux and ack
    reg [15:0] stat;
    // unused status bits read as zero
    always @* begin
        stat = `ISF_STAT_RST;
        stat[`ISF_B_ACK] = ack_q;
        stat[`ISF_B_TX] = master_tx_active_o;
        stat[`ISF_B_COLL] = coll_q;
        stat[`ISF_B_GCALL] = gc_q;
        stat[`ISF_B_TEN] = ten_q;
        stat[`ISF_B_WCOL] = wcol_q;
        stat[`ISF_B_OVF] = ovf_q;
        stat[`ISF_B_DA] = da_q;
        stat[`ISF_B_RBF] = full_q;
        // buffer-full mirrors the tx flag: the byte leaves as the transfer ends
        stat[`ISF_B_TBF] = master_tx_active_o;
    end
    // registered ack: one wait state; the ~ack term stops a second take
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (rd) begin
                case (wb_adr_i)
                    `ISF_OFF_STATUS: wb_dat_o <= {16'h0000, stat};
                    `ISF_OFF_TXHOLD: wb_dat_o <= {24'h000000, tx_byte_o};
                    `ISF_OFF_RXHOLD: wb_dat_o <= {24'h000000, rx_q};
                    `ISF_OFF_CTRL: wb_dat_o <= {24'h000000, ctrl_o};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

/* src/isf_sync.v */
`timescale 1ns/1ns
// ==========================================================
// two-flop synchroniser for bus event pins
module isf_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // data
    input wire [WIDTH-1:0] d_i,
    output reg [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] meta_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= {WIDTH{1'b0}};
            q_o <= {WIDTH{1'b0}};
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

/* verif/isf_seq_model.sv */
`timescale 1ns/1ns
module isf_seq_model (
    input wire clk_i,
    input wire tx_load_i,
    input wire nack_i,
    output wire bit_o,
    output wire slot_end_o,
    output wire slot_n_o
);
    // ==========================================================
    // byte sequence
    // eight bit strobes, two high two low, then the ack slot
    logic [5:0] n = 6'h00;
    always @(posedge clk_i) begin
        if (tx_load_i) n <= 6'h28;
        else if (n != 6'h00) n <= n - 6'h01;
    end
    assign bit_o = (n > 6'h08) && n[1];
    assign slot_end_o = (n != 6'h00) && (n < 6'h06);
    assign slot_n_o = nack_i;
endmodule

/* verif/isf_status_props.sv */
`timescale 1ns/1ns
module isf_status_props (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire busy_i,
    input wire ack_slot_end_i,
    input wire coll_det_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire tx_load_o,
    input wire master_tx_active_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire txw = take && wb_we_i && wb_adr_i == 4'h4;
    wire srd = wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
    property p_ack; take |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("late ack");
    property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack1: assert property (p_ack1) else $error("long ack");
    property p_busy; txw && master_tx_active_o |=> !tx_load_o [*2]; endproperty
    a_busy: assert property (p_busy) else $error("busy write taken");
    property p_load;
        txw && !master_tx_active_o && !$past(busy_i, 2) |=> tx_load_o;
    endproperty
    a_load: assert property (p_load) else $error("idle write lost");
    property p_bsyin; txw && $past(busy_i, 2) |=> !tx_load_o; endproperty
    a_bsyin: assert property (p_bsyin) else $error("write taken while busy");
    property p_start; tx_load_o |-> ##[0:2] master_tx_active_o; endproperty
    a_start: assert property (p_start) else $error("tx not active");
    property p_hold;
        $fell(master_tx_active_o) |-> $past(ack_slot_end_i, 3) || $past(coll_det_i, 3);
    endproperty
    a_hold: assert property (p_hold) else $error("tx ended early");
    property p_mirr; srd |-> wb_dat_o[0] == wb_dat_o[14]; endproperty
    a_mirr: assert property (p_mirr) else $error("tx bits differ");
    c_busy: cover property (txw && master_tx_active_o);
    c_end: cover property ($fell(master_tx_active_o));
    c_rd: cover property (srd);
    c_abort: cover property ($fell(master_tx_active_o) && $past(coll_det_i, 3));
endmodule
bind isf_status isf_status_props isf_status_props_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .busy_i, .ack_slot_end_i, .coll_det_i, .wb_dat_o, .wb_ack_o, .tx_load_o,
    .master_tx_active_o);

/* verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, nack = 1, bsy = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0, rd;
    logic [4:0] ev = 5'h00;
    logic [7:0] rxd = 8'h00;
    wire ack, se, sn, ld, mta, bt;
    wire [31:0] dout;
    wire [7:0] txb;
    integer errors = 0, n_tests = 0;
    isf_status isf_status_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
        .ack_slot_end_i(se), .ack_sampled_n_i(sn), .tx_start_i(bt), .coll_det_i(ev[0]),
        .stop_det_i(ev[1]), .gcall_match_i(ev[2]), .ten_match_i(ev[3]), .rx_byte_i(ev[4]),
        .rx_data_i(rxd), .busy_i(bsy), .data_byte_i(1'b0), .tx_load_o(ld),
        .tx_byte_o(txb), .master_tx_active_o(mta), .ctrl_o());
    isf_seq_model isf_seq_model_i (.clk_i, .tx_load_i(ld), .nack_i(nack), .bit_o(bt),
        .slot_end_o(se), .slot_n_o(sn));
    initial forever #5 clk_i = ~clk_i;
    task end_of_test;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        integer k;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge clk_i);
        if (k == 20) begin
            errors++;
            end_of_test;
        end
        rd = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task st(input string nm, input logic [31:0] exp);
        wb(1'b0, 4'h0, 32'h0);
        chk(nm, rd & 32'h0000c7c0, exp);
    endtask
    task pulse(input integer b);
        ev[b] <= 1'b1;
        repeat (3) @(posedge clk_i);
        ev[b] <= 1'b0;
        repeat (5) @(posedge clk_i);
    endtask
    task t_regs;
        st("reset", 32'h0);
        wb(1'b0, 4'h2, 32'h0);
        chk("unmapped", rd, 32'h0);
        wb(1'b1, 4'hc, 32'ha5);
        wb(1'b0, 4'hc, 32'h0);
        chk("ctrl", rd, 32'ha5);
        $display("test regs done");
    endtask
    task t_tx;
        wb(1'b1, 4'h4, 32'h5a);
        st("active", 32'h4000);
        wb(1'b1, 4'h4, 32'h33);
        st("wcol", 32'h4080);
        chk("txbyte", {24'h0, txb}, 32'h5a);
        wb(1'b1, 4'h0, 32'h80);
        repeat (50) @(posedge clk_i);
        st("nack", 32'h8000);
        nack <= 1'b0;
        wb(1'b1, 4'h4, 32'hc3);
        repeat (50) @(posedge clk_i);
        st("acked", 32'h0);
        bsy <= 1'b1;
        repeat (3) @(posedge clk_i);
        wb(1'b1, 4'h4, 32'h44);
        st("bsywcol", 32'h0080);
        chk("bsytx", {24'h0, txb}, 32'hc3);
        bsy <= 1'b0;
        wb(1'b1, 4'h0, 32'h80);
        $display("test tx done");
    endtask
    task t_flags;
        wb(1'b1, 4'h4, 32'h77);
        pulse(0);
        st("coll", 32'h0400);
        wb(1'b1, 4'h0, 32'h400);
        pulse(2);
        pulse(3);
        st("match", 32'h0300);
        pulse(1);
        st("stop", 32'h0);
        $display("test flags done");
    endtask
    task t_ovf;
        rxd <= 8'h11;
        pulse(4);
        rxd <= 8'h22;
        pulse(4);
        st("ovf", 32'h0040);
        wb(1'b0, 4'h8, 32'h0);
        chk("rxbyte", rd, 32'h11);
        wb(1'b1, 4'h0, 32'h40);
        st("ovfclr", 32'h0);
        $display("test ovf done");
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs;
        t_tx;
        t_flags;
        t_ovf;
        end_of_test;
    end
endmodule
